// [bench/fpec_cpu_model.sv]
// CPU core model: issues I/O and memory accesses to the flash controller.
// Assumes the stall is settled at the falling edge and inputs move after rising edges.
`timescale 1ns/1ps
`default_nettype none
module fpec_cpu_model (
    input wire logic clk,
    input wire logic cpu_wait,
    output logic [7:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata,
    output logic [23:0] mem_addr,
    output logic mem_wr,
    output logic mem_rd,
    output logic [7:0] mem_wdata
);
    logic w;
    // Quiet bus from time zero
    initial begin
        {io_addr, io_wr, io_rd, io_wdata, mem_addr, mem_wr, mem_rd, mem_wdata} = '0;
    end
    // One access: 0 I/O write, 1 I/O read, 2 memory write, 3 memory read
    task automatic acc(input logic [1:0] k, input logic [23:0] a, input logic [7:0] d);
        repeat (1 + $urandom_range(1, 0)) @(posedge clk);
        io_addr <= a[7:0];
        mem_addr <= a;
        io_wdata <= d;
        mem_wdata <= d;
        io_wr <= (k == 2'h0);
        io_rd <= (k == 2'h1);
        mem_wr <= (k == 2'h2);
        mem_rd <= (k == 2'h3);
        // Hold the request until an edge with the stall low takes it
        do begin
            @(negedge clk);
            w = cpu_wait;
            @(posedge clk);
        end while (w !== 1'b0);
        {io_wr, io_rd, mem_wr, mem_rd} <= 4'h0;
        io_wdata <= ~d;
        mem_wdata <= ~d;
    endtask
endmodule
`default_nettype wire

// [bench/tb_fpec_ctrl.sv]
// Self-checking bench of the flash program and erase controller.
// Assumes short erase and time-out counts set through the parameters.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.svh"
module tb_fpec_ctrl;
    import fpec_pkg::*;
    localparam logic [15:0] BYTE_ST = 16'(`FPEC_BYTE_CYC);
    localparam logic [15:0] ROW_ST = 16'(`FPEC_ROWB_CYC);
    logic clk = 1'b0, rst = 1'b1, flash_en = 1'b0, sram_hit = 1'b0;
    logic [7:0] io_addr, io_wdata, io_rdata, mem_wdata, fl_wdata, fl_div, d;
    logic io_wr, io_rd, mem_wr, mem_rd, cpu_wait, flash_sel, ext_cs_block;
    logic fl_info, fl_prog, fl_hv, fl_mass_erase, fl_page_erase, rd_pend = 1'b0, pp = 1'b0;
    logic [23:0] mem_addr, a;
    logic [16:0] fl_addr;
    logic [31:0] q_stall[$], q_rd[$], q_prog[$], e, r;
    int bad_count = 0, total_checks = 0, n = 0;
    always #10 clk = ~clk;
    fpec_ctrl #(.PAGE_CYC(24'd40), .MASS_CYC(24'd60), .ROWTMO_CYC(24'd5000)) u_dut (.clk(clk), .rst(rst),
        .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
        .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata), .flash_en(flash_en),
        .sram_hit(sram_hit), .cpu_wait(cpu_wait), .flash_sel(flash_sel), .ext_cs_block(ext_cs_block),
        .fl_addr(fl_addr), .fl_info(fl_info), .fl_wdata(fl_wdata), .fl_prog(fl_prog), .fl_hv(fl_hv),
        .fl_mass_erase(fl_mass_erase), .fl_page_erase(fl_page_erase), .fl_div(fl_div));
    fpec_cpu_model u_cpu (.clk(clk), .cpu_wait(cpu_wait), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .mem_addr(mem_addr), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wdata));
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Up to four I/O writes packed as {port, data}, zero pairs skipped
    task automatic wseq(input logic [63:0] v);
        for (int i = 3; i >= 0; i--) begin
            if (v[i*16 +: 16] != 16'h0000) u_cpu.acc(2'h0, {16'h0000, v[i*16+8 +: 8]}, v[i*16 +: 8]);
        end
    endtask
    task automatic rd(input logic [7:0] p, input logic [7:0] x);
        q_rd.push_back({24'h000000, x});
        u_cpu.acc(2'h1, {16'h0000, p}, 8'h00);
    endtask
    // Expected programming strobe and stall length of one byte
    task automatic note(input logic [16:0] fa, input logic inf, input logic [7:0] dv, input logic [15:0] st);
        q_stall.push_back({st, st});
        q_prog.push_back({6'h00, inf, fa, dv});
    endtask
    task automatic settle;
        @(negedge clk);
        for (int i = 0; i < 5000 && cpu_wait !== 1'b0; i++) @(negedge clk);
    endtask
    // Observer: read data, stall lengths and strobes against the oldest notes
    always @(negedge clk) begin
        if (rd_pend) chk("io_rdata", {24'h0, io_rdata}, q_rd.size() > 0 ? q_rd.pop_front() : 'x);
        rd_pend = io_rd && !cpu_wait && !rst;
        if (cpu_wait === 1'b1) n++;
        else if (n > 0) begin
            e = q_stall.size() > 0 ? q_stall.pop_front() : 32'h0;
            chk("stall", 32'(n >= int'(e[15:0]) && n <= int'(e[31:16])), 32'h1);
            n = 0;
        end
        if (fl_prog === 1'b1 && !pp) chk("prog", {6'h0, fl_info, fl_addr, fl_wdata},
            q_prog.size() > 0 ? q_prog.pop_front() : 'x);
        pp = fl_prog;
    end
    // Watchdog reckoned from about 20000 cycles of tests
    initial begin
        #(60000 * 20);
        bad_count++;
        conclude();
    end
    // Main sequence
    initial begin
        r = $urandom(32'hCD89);
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        flash_en <= 1'b1;
        rd(8'hF9, 8'h01);
        rd(8'hFA, 8'hFF);
        rd(8'hFB, 8'h00);
        rd(8'hF7, 8'h00);
        // Broken key, then a good key with reads between, then relock
        wseq(64'hF5B6_FC00_F549_FA00);
        rd(8'hFA, 8'hFF);
        wseq(64'hF5B6);
        rd(8'hF5, 8'h00);
        u_cpu.acc(2'h3, 24'h800000, 8'h00);
        wseq(64'hF549_FA00_F907);
        rd(8'hFA, 8'h00);
        rd(8'hF9, 8'h01);
        // Unlock again and move the divider, which relocks
        wseq(64'hF5B6_F549_F907);
        rd(8'hF9, 8'h07);
        chk("div", 32'(fl_div), 32'h7);
        // Single byte through the data port, read back once the stall ends
        d = 8'($urandom);
        wseq(64'hFC05_FD03_FE11_FF00);
        note({7'h05, 3'h3, 7'h11}, 1'b0, d, BYTE_ST);
        wseq({48'h0, 8'hF6, d});
        rd(8'hF6, d);
        // Two row bytes up to the last column, high voltage held between
        wseq(64'hFC05_FD04_FE7E_FF01);
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom);
            note({7'h05, 3'h4, 7'(8'h7E + k)}, 1'b0, d, ROW_ST);
            wseq({48'h0, 8'hF6, d});
            settle();
            chk("hv", 32'(fl_hv), 32'(k == 0));
        end
        rd(8'hFF, 8'h00);
        // Row abandoned after one byte runs into the time-out
        wseq(64'hF703_FE00_FF01);
        note({7'h05, 3'h4, 7'h00}, 1'b0, d, ROW_ST);
        wseq({48'h0, 8'hF6, d});
        repeat (7100) @(posedge clk);
        rd(8'hF7, 8'h02);
        rd(8'hFF, 8'h00);
        // Base mapping, chip-select suppression, memory write
        wseq(64'hFB03);
        rd(8'hFB, 8'h02);
        a = {8'h02, 16'($urandom)};
        note(a[16:0], 1'b0, d, BYTE_ST);
        u_cpu.acc(2'h2, a, d);
        // Selects are only decoded while a memory request stands
        fork
            u_cpu.acc(2'h3, a, 8'h00);
            begin
                wait (mem_rd === 1'b1);
                @(negedge clk);
                chk("sel", 32'({flash_sel, ext_cs_block}), 32'h3);
            end
        join
        sram_hit <= 1'b1;
        fork
            u_cpu.acc(2'h3, a, 8'h00);
            begin
                wait (mem_rd === 1'b1);
                @(negedge clk);
                chk("sram", 32'({flash_sel, ext_cs_block}), 32'h0);
            end
        join
        sram_hit <= 1'b0;
        settle();
        // Information page erase, self-timed with no stall
        wseq(64'hF703_FC80_FF04);
        @(negedge clk);
        chk("perase", {cpu_wait, fl_page_erase, fl_info, fl_wdata}, {21'h0, 3'h3, `FPEC_ERASED});
        for (int i = 0; i < 100 && fl_page_erase !== 1'b0; i++) @(negedge clk);
        rd(8'hF7, 8'h01);
        // Mass erase holds a data port read until it ends
        wseq(64'hF701_FF02);
        @(negedge clk);
        chk("merase", {fl_mass_erase, fl_wdata}, {23'h0, 1'b1, `FPEC_ERASED});
        q_stall.push_back({16'd60, 16'd40});
        rd(8'hF6, d);
        rd(8'hF7, 8'h01);
        // Locked write forces full protection; data port write is then refused
        wseq(64'hFA00_FC05_FF06_F6A5);
        settle();
        chk("prot", 32'({cpu_wait, fl_prog, fl_mass_erase, fl_page_erase}), 32'h0);
        for (int i = 0; i < 100 && (q_stall.size() + q_rd.size() + q_prog.size()) > 0; i++) @(negedge clk);
        chk("drain", q_stall.size() + q_rd.size() + q_prog.size(), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire

// [logic/fpec_ctrl.sv]
// Flash program and erase sequencer with its I/O registers and memory decode.
// Assumes a CPU that holds any request while cpu_wait is high, and an array
// that programs or erases while the matching strobes stand.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.svh"
// Function
// - Row programming only while row enable set; same address and data registers.
// - Each row byte written stalls the CPU until it is programmed.
// - High voltage stays on through the row; 41 to 52 us per byte.
// - Row time-out aborts the row and sets a sticky error bit.
// - Column increments after each row byte; at most 128 bytes.
// - Memory write programs one byte and stalls 66 to 85 us.
// - Erase leaves every erased byte reading FFh.
// - Erases are self-timed, no stall, and set a done bit.
// - Flash accesses during erase wait until the erase ends.
// - Mass erase clears main array and information page, about 200 ms.
// - Page erase clears the selected page, about 10 ms.
// - Page select bit 7 picks information page; memory path never reaches it.
// - Key writes B6h then 49h unlock divider and protection registers.
// - Only I/O writes affect unlock; a wrong sequence stays locked.
// - Writing divider or protection register relocks both.
// - Data port reads return last written value.
// - Data port write with row mode off programs one byte.
// - Flash base is upper bits 7:1, zero, 0000h; bit 0 reads zero.
// - Flash hit suppresses external selects; internal SRAM wins over flash.
// - Write or erase to a protected 16 KB block is blocked, except row bytes after the first of a row.
module fpec_ctrl #(
    parameter logic [`FPEC_TW-1:0] PAGE_CYC = `FPEC_TW'(`FPEC_PAGE_CYC),
    parameter logic [`FPEC_TW-1:0] MASS_CYC = `FPEC_TW'(`FPEC_MASS_CYC),
    parameter logic [`FPEC_TW-1:0] ROWTMO_CYC = `FPEC_TW'(`FPEC_ROWTMO_CYC)
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic [23:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [7:0] mem_wdata,
    input wire logic flash_en,
    input wire logic sram_hit,
    output logic cpu_wait,
    output logic flash_sel,
    output logic ext_cs_block,
    output logic [16:0] fl_addr,
    output logic fl_info,
    output logic [7:0] fl_wdata,
    output logic fl_prog,
    output logic fl_hv,
    output logic fl_mass_erase,
    output logic fl_page_erase,
    output logic [7:0] fl_div
);
    import fpec_pkg::*;
    fpec_regs_t st_ff;
    fpec_regs_t nxt_st;
    logic tmr_load;
    logic [`FPEC_TW-1:0] tmr_val;
    logic tmr_exp;
    logic rto_load;
    logic [`FPEC_TW-1:0] rto_val;
    logic rto_exp;
    logic unlocked;
    logic io_ok;
    logic data_wr;
    logic mem_go;
    logic flash_acc;
    logic io_page_ok;
    logic in_row;

    // Address falls inside the 128 KB flash window
    function automatic logic fpec_hit(input logic [23:0] a, input logic [6:0] b);
        return a[23:17] == b;
    endfunction

    // Protection bit of the 16 KB block holding a page
    function automatic logic fpec_blk(input logic [7:0] p, input logic [2:0] blk);
        return p[blk];
    endfunction

    // Memory decode and chip-select priority
    assign flash_sel = flash_en && !sram_hit && (mem_rd || mem_wr)
        && fpec_hit(mem_addr, st_ff.base);
    assign ext_cs_block = flash_sel;

    // Any access that touches the array
    assign flash_acc = flash_sel || ((io_rd || io_wr) && io_addr == `FPEC_DATA_OFS);
    assign in_row = (st_ff.state == S_ROWB) || (st_ff.state == S_ROWG);

    // Stall while a byte programs, a flash access meets an erase, or a flash memory write meets a row gap
    assign cpu_wait = (st_ff.state == S_BYTE) || (st_ff.state == S_ROWB)
        || (st_ff.state == S_ERASE && flash_acc)
        || (st_ff.state == S_ROWG && mem_wr && flash_sel);

    // Accepted requests
    assign io_ok = io_wr && !cpu_wait;
    assign data_wr = io_ok && io_addr == `FPEC_DATA_OFS;
    assign mem_go = mem_wr && flash_sel && !cpu_wait;
    assign io_page_ok = st_ff.page[`FPEC_INFO_BIT] || !fpec_blk(st_ff.prot, st_ff.page[6:4]);

    // Register file and sequencer
    always_comb begin
        nxt_st = st_ff;
        tmr_load = 1'b0;
        tmr_val = '0;
        rto_load = 1'b0;
        rto_val = '0;
        if (io_rd && !cpu_wait) begin
            case (io_addr)
                `FPEC_DATA_OFS: nxt_st.rdata = st_ff.data;
                `FPEC_STAT_OFS: nxt_st.rdata = {6'h00, st_ff.rto, st_ff.done};
                `FPEC_FDIV_OFS: nxt_st.rdata = st_ff.fdiv;
                `FPEC_PROT_OFS: nxt_st.rdata = st_ff.prot;
                `FPEC_BASE_OFS: nxt_st.rdata = {st_ff.base, 1'b0};
                `FPEC_PAGE_OFS: nxt_st.rdata = st_ff.page;
                `FPEC_ROW_OFS: nxt_st.rdata = {5'h00, st_ff.row};
                `FPEC_COL_OFS: nxt_st.rdata = {1'b0, st_ff.col};
                `FPEC_PGCTL_OFS: nxt_st.rdata = {5'h00, st_ff.state == S_ERASE && !st_ff.emass,
                    st_ff.state == S_ERASE && st_ff.emass, st_ff.rowen};
                default: nxt_st.rdata = `FPEC_ZERO8;
            endcase
        end
        if (io_ok) begin
            case (io_addr)
                `FPEC_DATA_OFS: nxt_st.data = io_wdata;
                `FPEC_STAT_OFS: begin
                    nxt_st.done = st_ff.done && !io_wdata[`FPEC_DONE_BIT];
                    nxt_st.rto = st_ff.rto && !io_wdata[`FPEC_RTO_BIT];
                end
                `FPEC_FDIV_OFS: begin
                    if (unlocked) begin
                        nxt_st.fdiv = io_wdata;
                    end
                end
                `FPEC_PROT_OFS: nxt_st.prot = unlocked ? io_wdata : `FPEC_PROT_RST;
                `FPEC_BASE_OFS: nxt_st.base = io_wdata[7:1];
                `FPEC_PAGE_OFS: nxt_st.page = io_wdata;
                `FPEC_ROW_OFS: nxt_st.row = io_wdata[2:0];
                `FPEC_COL_OFS: nxt_st.col = io_wdata[6:0];
                `FPEC_PGCTL_OFS: nxt_st.rowen = io_wdata[`FPEC_ROWEN_BIT];
                default: nxt_st.rowen = st_ff.rowen;
            endcase
        end
        case (st_ff.state)
            S_IDLE: begin
                if (mem_go) begin
                    if (!fpec_blk(st_ff.prot, mem_addr[16:14])) begin
                        nxt_st.state = S_BYTE;
                        nxt_st.faddr = mem_addr[16:0];
                        nxt_st.finfo = 1'b0;
                        nxt_st.fwdata = mem_wdata;
                        tmr_load = 1'b1;
                        tmr_val = `FPEC_TW'(`FPEC_BYTE_CYC);
                    end
                end else if (data_wr && io_page_ok) begin
                    nxt_st.faddr = {st_ff.page[6:0], st_ff.row, st_ff.col};
                    nxt_st.finfo = st_ff.page[`FPEC_INFO_BIT];
                    nxt_st.fwdata = io_wdata;
                    tmr_load = 1'b1;
                    if (st_ff.rowen) begin
                        nxt_st.state = S_ROWB;
                        nxt_st.hv = 1'b1;
                        tmr_val = `FPEC_TW'(`FPEC_ROWB_CYC);
                        rto_load = 1'b1;
                        rto_val = ROWTMO_CYC;
                    end else begin
                        nxt_st.state = S_BYTE;
                        tmr_val = `FPEC_TW'(`FPEC_BYTE_CYC);
                    end
                end else if (io_ok && io_addr == `FPEC_PGCTL_OFS) begin
                    nxt_st.faddr = {st_ff.page[6:0], 10'h000};
                    nxt_st.finfo = st_ff.page[`FPEC_INFO_BIT];
                    nxt_st.fwdata = `FPEC_ERASED;
                    if (io_wdata[`FPEC_MASS_BIT] && st_ff.prot == `FPEC_ZERO8) begin
                        nxt_st.state = S_ERASE;
                        nxt_st.emass = 1'b1;
                        tmr_load = 1'b1;
                        tmr_val = MASS_CYC;
                    end else if (io_wdata[`FPEC_PGER_BIT] && io_page_ok) begin
                        nxt_st.state = S_ERASE;
                        nxt_st.emass = 1'b0;
                        tmr_load = 1'b1;
                        tmr_val = PAGE_CYC;
                    end
                end
            end
            S_BYTE: begin
                if (tmr_exp) begin
                    nxt_st.state = S_IDLE;
                end
            end
            S_ROWB: begin
                if (rto_exp) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.hv = 1'b0;
                    nxt_st.rowen = 1'b0;
                    nxt_st.rto = 1'b1;
                end else if (tmr_exp) begin
                    nxt_st.col = st_ff.col + 7'h01;
                    if (st_ff.col == `FPEC_LAST_COL) begin
                        nxt_st.state = S_IDLE;
                        nxt_st.hv = 1'b0;
                        nxt_st.rowen = 1'b0;
                        rto_load = 1'b1;
                    end else begin
                        nxt_st.state = S_ROWG;
                    end
                end
            end
            S_ROWG: begin
                if (rto_exp) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.hv = 1'b0;
                    nxt_st.rowen = 1'b0;
                    nxt_st.rto = 1'b1;
                end else if (!st_ff.rowen) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.hv = 1'b0;
                    rto_load = 1'b1;
                end else if (data_wr) begin
                    nxt_st.state = S_ROWB;
                    nxt_st.faddr = {st_ff.page[6:0], st_ff.row, st_ff.col};
                    nxt_st.fwdata = io_wdata;
                    tmr_load = 1'b1;
                    tmr_val = `FPEC_TW'(`FPEC_ROWB_CYC);
                end
            end
            S_ERASE: begin
                if (tmr_exp) begin
                    nxt_st.state = S_IDLE;
                    nxt_st.done = 1'b1;
                end
            end
            default: nxt_st.state = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '{state: S_IDLE, fdiv: `FPEC_FDIV_RST, prot: `FPEC_PROT_RST, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Operation timer and row time-out timer
    fpec_timer u_op_tmr (
        .clk(clk),
        .rst(rst),
        .load(tmr_load),
        .load_val(tmr_val),
        .expire(tmr_exp)
    );
    fpec_timer u_rto_tmr (
        .clk(clk),
        .rst(rst),
        .load(rto_load),
        .load_val(rto_val),
        .expire(rto_exp)
    );

    // Key tracker fed by accepted I/O writes only
    fpec_unlock u_unlock (
        .clk(clk),
        .rst(rst),
        .key_wr(io_ok && io_addr == `FPEC_KEY_OFS),
        .other_wr(io_ok && io_addr != `FPEC_KEY_OFS),
        .wdata(io_wdata),
        .relock(io_ok && (io_addr == `FPEC_FDIV_OFS || io_addr == `FPEC_PROT_OFS)),
        .unlocked(unlocked)
    );

    // Array side outputs
    assign io_rdata = st_ff.rdata;
    assign fl_addr = st_ff.faddr;
    assign fl_info = st_ff.finfo;
    assign fl_wdata = st_ff.fwdata;
    assign fl_prog = (st_ff.state == S_BYTE) || (st_ff.state == S_ROWB);
    assign fl_hv = st_ff.hv || (st_ff.state == S_BYTE);
    assign fl_mass_erase = (st_ff.state == S_ERASE) && st_ff.emass;
    assign fl_page_erase = (st_ff.state == S_ERASE) && !st_ff.emass;
    assign fl_div = st_ff.fdiv;

    // Cycles spent in a programming state
    logic [15:0] plen_ff;
    always_ff @(posedge clk) begin
        if (rst) begin
            plen_ff <= 16'h0000;
        end else if (fl_prog) begin
            plen_ff <= plen_ff + 16'h0001;
        end else begin
            plen_ff <= 16'h0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_byte_time:
    assert property ($past(st_ff.state == S_BYTE) && st_ff.state != S_BYTE
        |-> plen_ff == 16'(`FPEC_BYTE_CYC)) else $error("byte program time wrong");
    a_row_time:
    assert property ($past(st_ff.state == S_ROWB) && st_ff.state == S_ROWG
        |-> plen_ff == 16'(`FPEC_ROWB_CYC)) else $error("row byte time wrong");
    a_row_hv:
    assert property (in_row |-> fl_hv) else $error("high voltage dropped in row");
    a_row_stall:
    assert property (data_wr && st_ff.state == S_ROWG && st_ff.rowen && !rto_exp
        |=> cpu_wait [*8]) else $error("row byte not stalled");
    a_rto_abort:
    assert property ($rose(st_ff.rto) |-> st_ff.state == S_IDLE && !fl_hv && !st_ff.rowen)
        else $error("row time-out did not abort");
    a_col_step:
    assert property ($past(st_ff.state == S_ROWB) && st_ff.state == S_ROWG
        |-> st_ff.col == $past(st_ff.col) + 7'h01) else $error("column not stepped");
    a_erase_hold:
    assert property (st_ff.state == S_ERASE && flash_acc |-> cpu_wait)
        else $error("access not held during erase");
    a_erase_done:
    assert property (st_ff.state == S_ERASE && tmr_exp |=> st_ff.done && st_ff.state == S_IDLE)
        else $error("erase end without done");
    a_data_rback:
    assert property (io_rd && !cpu_wait && io_addr == `FPEC_DATA_OFS |=> io_rdata == $past(st_ff.data))
        else $error("data port readback wrong");
    a_key_relock:
    assert property (io_ok && (io_addr == `FPEC_FDIV_OFS || io_addr == `FPEC_PROT_OFS) |=> !unlocked)
        else $error("divider or protection write did not relock");
    a_mass_block:
    assert property (st_ff.state == S_IDLE && io_ok && io_addr == `FPEC_PGCTL_OFS
        && st_ff.prot == `FPEC_PROT_RST |=> !fl_mass_erase && (fl_info || !fl_page_erase))
        else $error("erase of protected flash");
    a_sram_first:
    assert property (sram_hit |-> !flash_sel && !ext_cs_block) else $error("flash beat internal SRAM");

    c_byte_done: cover property (st_ff.state == S_BYTE ##1 st_ff.state == S_IDLE);
    c_row_end: cover property (st_ff.state == S_ROWB && tmr_exp && st_ff.col == `FPEC_LAST_COL);
    c_erase_end: cover property (st_ff.state == S_ERASE && tmr_exp);
    c_unlock: cover property ($rose(unlocked));
endmodule
`default_nettype wire

// [logic/fpec_defs.svh]
// Constants of the flash program and erase controller: ports, fields, resets, times.
// Assumes a 50 MHz system clock and an 8-bit I/O port address space.
`ifndef FPEC_DEFS_SVH
`define FPEC_DEFS_SVH
// I/O port addresses
`define FPEC_KEY_OFS 8'hF5
`define FPEC_DATA_OFS 8'hF6
`define FPEC_STAT_OFS 8'hF7
`define FPEC_FDIV_OFS 8'hF9
`define FPEC_PROT_OFS 8'hFA
`define FPEC_BASE_OFS 8'hFB
`define FPEC_PAGE_OFS 8'hFC
`define FPEC_ROW_OFS 8'hFD
`define FPEC_COL_OFS 8'hFE
`define FPEC_PGCTL_OFS 8'hFF
// Field positions
`define FPEC_INFO_BIT 7
`define FPEC_ROWEN_BIT 0
`define FPEC_MASS_BIT 1
`define FPEC_PGER_BIT 2
`define FPEC_DONE_BIT 0
`define FPEC_RTO_BIT 1
// Reset values and fixed codes
`define FPEC_PROT_RST 8'hFF
`define FPEC_FDIV_RST 8'h01
`define FPEC_KEY1 8'hB6
`define FPEC_KEY2 8'h49
`define FPEC_ERASED 8'hFF
`define FPEC_LAST_COL 7'h7F
`define FPEC_ZERO8 8'h00
// Timing, figures in their own units
`define FPEC_TW 24
`define FPEC_TMR_ONE 24'h000001
`define FPEC_CLK_MHZ 50
`define FPEC_BYTE_US 66
`define FPEC_ROWB_US 41
`define FPEC_PAGE_MS 10
`define FPEC_MASS_MS 200
`define FPEC_ROWTMO_MS 16
`define FPEC_BYTE_CYC (`FPEC_BYTE_US * `FPEC_CLK_MHZ)
`define FPEC_ROWB_CYC (`FPEC_ROWB_US * `FPEC_CLK_MHZ)
`define FPEC_PAGE_CYC (`FPEC_PAGE_MS * 1000 * `FPEC_CLK_MHZ)
`define FPEC_MASS_CYC (`FPEC_MASS_MS * 1000 * `FPEC_CLK_MHZ)
`define FPEC_ROWTMO_CYC (`FPEC_ROWTMO_MS * 1000 * `FPEC_CLK_MHZ)
`endif

// [logic/fpec_pkg.sv]
// Types of the flash program and erase controller.
// Assumes fpec_defs.svh is on the include path.
`include "fpec_defs.svh"
package fpec_pkg;
    typedef enum logic [2:0] {S_IDLE, S_BYTE, S_ROWB, S_ROWG, S_ERASE} fpec_state_t;
    typedef enum logic [1:0] {U_LOCK, U_FIRST, U_OPEN} fpec_unl_state_t;
    typedef struct packed {
        fpec_unl_state_t state;
    } fpec_unl_t;
    typedef struct packed {
        logic [`FPEC_TW-1:0] cnt;
    } fpec_tmr_t;
    typedef struct packed {
        fpec_state_t state;
        logic [7:0] page;
        logic [2:0] row;
        logic [6:0] col;
        logic [7:0] data;
        logic rowen;
        logic done;
        logic rto;
        logic [7:0] fdiv;
        logic [7:0] prot;
        logic [6:0] base;
        logic [7:0] rdata;
        logic [16:0] faddr;
        logic finfo;
        logic [7:0] fwdata;
        logic hv;
        logic emass;
    } fpec_regs_t;
endpackage

// [logic/fpec_timer.sv]
// Down counter that times programming, erase and row time-out.
// Assumes load and value come from the controller's clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.svh"
module fpec_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [`FPEC_TW-1:0] load_val,
    output logic expire
);
    import fpec_pkg::*;
    fpec_tmr_t st_ff;
    fpec_tmr_t nxt_st;

    // Load wins, else count down to zero
    always_comb begin
        nxt_st = st_ff;
        if (load) begin
            nxt_st.cnt = load_val;
        end else if (st_ff.cnt != '0) begin
            nxt_st.cnt = st_ff.cnt - `FPEC_TMR_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Last counted cycle
    assign expire = (st_ff.cnt == `FPEC_TMR_ONE) && !load;
endmodule
`default_nettype wire

// [logic/fpec_unlock.sv]
// Two-byte key tracker guarding the divider and protection registers.
// Assumes strobes are accepted I/O writes, one cycle each.
`timescale 1ns/1ps
`default_nettype none
`include "fpec_defs.svh"
module fpec_unlock (
    input wire logic clk,
    input wire logic rst,
    input wire logic key_wr,
    input wire logic other_wr,
    input wire logic [7:0] wdata,
    input wire logic relock,
    output logic unlocked
);
    import fpec_pkg::*;
    fpec_unl_t st_ff;
    fpec_unl_t nxt_st;

    // Only I/O writes move the tracker
    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            U_LOCK: begin
                if (key_wr && wdata == `FPEC_KEY1) begin
                    nxt_st.state = U_FIRST;
                end
            end
            U_FIRST: begin
                if (key_wr && wdata == `FPEC_KEY2) begin
                    nxt_st.state = U_OPEN;
                end else if (key_wr || other_wr) begin
                    nxt_st.state = U_LOCK;
                end
            end
            U_OPEN: begin
                if (relock) begin
                    nxt_st.state = U_LOCK;
                end
            end
            default: nxt_st.state = U_LOCK;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_ff <= '{state: U_LOCK};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign unlocked = (st_ff.state == U_OPEN);
endmodule
`default_nettype wire
